//--- hw/gtu_top.sv
// General-purpose timer unit: split timer, legacy timers, capture timer
// ***************************************************************
// Notes on behaviour
// RL1 - Split enable runs the timer as two independent 8-bit auto-reload halves.
// RL2 - Low half reloads from low reload, high half from high reload.
// RL3 - Run bit gates only the high half; low half always counts in split.
// RL4 - Select set: system clock; clear: clock/12, or external/8 if external select.
// RL5 - Each half sets its own overflow flag on overflow from FF to its reload value.
// RL6 - With timer interrupt enabled, every high half overflow interrupts.
// RL7 - With low-overflow enable, either half interrupts; software checks flags.
// RL8 - Only software clears the overflow flags, never hardware.
// RL9 - Gate set: timer runs only with run bit and active external irq.
// RL10 - Count select: internal clock when clear, count pin falling edge when set.
// RL11 - Second legacy timer modes: 13-bit, 16-bit, 8-bit reload, inactive.
// RL12 - First legacy timer modes: 13, 16, 8-bit reload, or two 8-bit timers.
// RL13 - Low byte register holds 16-bit low byte, or whole low half in split.
// RL14 - Reload low supplies reload value; in capture mode it takes the count.
// RL15 - On overflow a half loads its reload value in the flag cycle.
// RL16 - External clock and count pins are synchronised, edges found on system clock.
// ***************************************************************
//
// The address-and-strobe port was decided locally.
`timescale 1ns/100ps
`default_nettype none
`include "gtu_consts.svh"
module gtu_top (
  // Clock and reset
  input  wire logic       clk_sys,
  input  wire logic       sys_rst,
  // Register port
  input  wire logic [7:0] addr,
  input  wire logic [7:0] wdata,
  input  wire logic       wr,
  input  wire logic       rd,
  output logic      [7:0] rdata,
  // External pins
  input  wire logic       ext_clk_in,
  input  wire logic       count_pin_a,
  input  wire logic       count_pin_b,
  input  wire logic       external_irq_input_a,
  input  wire logic       external_irq_input_b,
  input  wire logic       capture_pin,
  // Interrupt
  output logic            irq
);
  localparam int NPIN = 6;
  localparam int P_EXT = 0;
  localparam int P_CA = 1;
  localparam int P_CB = 2;
  localparam int P_IA = 3;
  localparam int P_IB = 4;
  localparam int P_CAP = 5;

  gtu_pkg::gtu_state_t st;
  gtu_pkg::gtu_state_t next_st;

  logic [NPIN-1:0] pin_raw;
  logic [NPIN-1:0] pin_lvl;
  logic [NPIN-1:0] pin_rise;
  logic [NPIN-1:0] pin_fall;
  logic            div12;
  logic            ext_tick;
  logic            lo_tick;
  logic            hi_tick;
  logic            split;
  logic            run;
  logic [4:0]      wclr;
  logic [4:0]      ev;
  logic [4:0]      irq_gate;
  logic            irq_a_ok;
  logic            irq_b_ok;
  logic [7:0]      la_lo;
  logic [7:0]      la_hi;
  logic [7:0]      lb_lo;
  logic [7:0]      lb_hi;
  logic            la_ovf;
  logic            la_ovf_hi;
  logic            lb_ovf;

  // ***************************************************************
  // Pin synchronisers
  // ***************************************************************
  assign pin_raw = {capture_pin, external_irq_input_b, external_irq_input_a,
                    count_pin_b, count_pin_a, ext_clk_in};

  // RL16 synchronised pins
  for (genvar i = 0; i < NPIN; i++) begin : g_sync
    gtu_sync u_sync (
      .clk_sys (clk_sys),
      .sys_rst (sys_rst),
      .pin     (pin_raw[i]),
      .level   (pin_lvl[i]),
      .rise    (pin_rise[i]),
      .fall    (pin_fall[i])
    );
  end

  // ***************************************************************
  // Clock selection
  // ***************************************************************
  function automatic logic pick_tick(input logic sel, input logic xclk,
                                     input logic d12, input logic e8);
    pick_tick = sel ? 1'b1 : (xclk ? e8 : d12);
  endfunction : pick_tick

  assign div12    = (st.pre12 == `GTU_PRE12_LAST);
  assign ext_tick = pin_rise[P_EXT] & (st.ext8 == `GTU_EXT8_LAST);
  // RL4 per half clock
  assign lo_tick  = pick_tick(st.cksel[`GTU_B_LSEL], st.cctl[`GTU_B_XCLK], div12, ext_tick);
  assign hi_tick  = pick_tick(st.cksel[`GTU_B_HSEL], st.cctl[`GTU_B_XCLK], div12, ext_tick);
  assign split    = st.cctl[`GTU_B_SPLIT];
  assign run      = st.cctl[`GTU_B_RUN];

  // RL9 irq at polarity
  assign irq_a_ok = pin_lvl[P_IA] == st.irqcfg[`GTU_B_POL_A];
  assign irq_b_ok = pin_lvl[P_IB] == st.irqcfg[`GTU_B_POL_B];

  // ***************************************************************
  // Legacy timers
  // ***************************************************************
  gtu_legacy #(.SPLIT3(1'b1)) u_leg_a (
    .clk_sys  (clk_sys),
    .sys_rst  (sys_rst),
    .gate     (st.mode[`GTU_B_GATE]),
    .ct       (st.mode[`GTU_B_CT]),
    .mode     (gtu_pkg::gtu_lmode_t'(st.mode[1:0])),
    .run      (st.lctl[`GTU_B_RUN_A]),
    .run_hi   (st.lctl[`GTU_B_RUN_B]),
    .irq_ok   (irq_a_ok),
    .tick     (div12),
    .pin_fall (pin_fall[P_CA]),
    .ld_lo    (wr && addr == `GTU_A_LA_LO),
    .ld_hi    (wr && addr == `GTU_A_LA_HI),
    .wdata    (wdata),
    .count_lo (la_lo),
    .count_hi (la_hi),
    .ovf      (la_ovf),
    .ovf_hi   (la_ovf_hi)
  );

  gtu_legacy #(.SPLIT3(1'b0)) u_leg_b (
    .clk_sys  (clk_sys),
    .sys_rst  (sys_rst),
    .gate     (st.mode[`GTU_B_GATE + `GTU_B_TMRB]),
    .ct       (st.mode[`GTU_B_CT + `GTU_B_TMRB]),
    .mode     (gtu_pkg::gtu_lmode_t'(st.mode[5:4])),
    .run      (st.lctl[`GTU_B_RUN_B]),
    .run_hi   (1'b0),
    .irq_ok   (irq_b_ok),
    .tick     (div12),
    .pin_fall (pin_fall[P_CB]),
    .ld_lo    (wr && addr == `GTU_A_LB_LO),
    .ld_hi    (wr && addr == `GTU_A_LB_HI),
    .wdata    (wdata),
    .count_lo (lb_lo),
    .count_hi (lb_hi),
    .ovf      (lb_ovf),
    .ovf_hi   ()
  );

  // ***************************************************************
  // Next state
  // ***************************************************************
  assign wclr = (wr && addr == `GTU_A_STAT) ? wdata[4:0] : 5'h0;

  always_comb begin
    next_st = st;
    ev      = 5'h0;
    next_st.pre12 = div12 ? 4'h0 : 4'(st.pre12 + 4'h1);
    if (pin_rise[P_EXT]) begin
      next_st.ext8 = 3'(st.ext8 + 3'h1);
    end
    if (split) begin
      // RL3 low half free
      if (lo_tick) begin
        // RL15 low half reload
        if (st.clow == `GTU_BYTE_MAX) begin
          // RL2 low reload source
          next_st.clow = st.crll;
          // RL5 low overflow flag
          ev[`GTU_S_LO] = 1'b1;
        end else begin
          next_st.clow = 8'(st.clow + 8'h1);
        end
      end
      // RL1 independent high half
      if (run && hi_tick) begin
        // RL15 high half reload
        if (st.chigh == `GTU_BYTE_MAX) begin
          next_st.chigh = st.crlh;
          // RL5 high overflow flag
          ev[`GTU_S_HI] = 1'b1;
        end else begin
          next_st.chigh = 8'(st.chigh + 8'h1);
        end
      end
    end else if (run && lo_tick) begin
      // RL13 sixteen bit count
      if ({st.chigh, st.clow} == {`GTU_BYTE_MAX, `GTU_BYTE_MAX}) begin
        {next_st.chigh, next_st.clow} = {st.crlh, st.crll};
        ev[`GTU_S_HI] = 1'b1;
      end else begin
        {next_st.chigh, next_st.clow} = 16'({st.chigh, st.clow} + 16'h1);
      end
    end
    if (st.dctl[`GTU_B_RUN] && div12) begin
      if (st.dctl[`GTU_B_CAPT]) begin
        next_st.dlow = 8'(st.dlow + 8'h1);
      end else begin
        // RL14 reload low byte
        next_st.dlow = (st.dlow == `GTU_BYTE_MAX) ? st.drll : 8'(st.dlow + 8'h1);
      end
    end
    // RL14 capture low count
    if (st.dctl[`GTU_B_CAPT] && pin_fall[P_CAP]) begin
      next_st.drll   = st.dlow;
      ev[`GTU_S_CAP] = 1'b1;
    end
    ev[`GTU_S_LA] = la_ovf;
    ev[`GTU_S_LB] = lb_ovf | la_ovf_hi;
    if (wr) begin
      case (addr)
        `GTU_A_LCTL:   next_st.lctl   = wdata;
        `GTU_A_MODE:   next_st.mode   = wdata;
        `GTU_A_CKSEL:  next_st.cksel  = wdata;
        `GTU_A_DCTL:   next_st.dctl   = wdata;
        `GTU_A_DRLL:   next_st.drll   = wdata;
        `GTU_A_DLOW:   next_st.dlow   = wdata;
        `GTU_A_CCTL:   next_st.cctl   = wdata;
        `GTU_A_CRLL:   next_st.crll   = wdata;
        `GTU_A_CRLH:   next_st.crlh   = wdata;
        `GTU_A_CLOW:   next_st.clow   = wdata;
        `GTU_A_CHIGH:  next_st.chigh  = wdata;
        `GTU_A_IRQCFG: next_st.irqcfg = wdata;
        `GTU_A_MASK:   next_st.mask   = wdata[4:0];
        default:       next_st.mask   = st.mask;
      endcase
    end
    // RL8 flags only by software
    next_st.stat = (st.stat & ~wclr) | ev;
    next_st.rdata = `GTU_READ_NONE;
    if (rd) begin
      case (addr)
        `GTU_A_LCTL:   next_st.rdata = st.lctl;
        `GTU_A_MODE:   next_st.rdata = st.mode;
        `GTU_A_LA_LO:  next_st.rdata = la_lo;
        `GTU_A_LB_LO:  next_st.rdata = lb_lo;
        `GTU_A_LA_HI:  next_st.rdata = la_hi;
        `GTU_A_LB_HI:  next_st.rdata = lb_hi;
        `GTU_A_CKSEL:  next_st.rdata = st.cksel;
        `GTU_A_DCTL:   next_st.rdata = st.dctl;
        `GTU_A_DRLL:   next_st.rdata = st.drll;
        `GTU_A_DLOW:   next_st.rdata = st.dlow;
        `GTU_A_CCTL:   next_st.rdata = {st.stat[`GTU_S_HI], st.stat[`GTU_S_LO], st.cctl[5:0]};
        `GTU_A_CRLL:   next_st.rdata = st.crll;
        `GTU_A_CRLH:   next_st.rdata = st.crlh;
        `GTU_A_CLOW:   next_st.rdata = st.clow;
        `GTU_A_CHIGH:  next_st.rdata = st.chigh;
        `GTU_A_IRQCFG: next_st.rdata = st.irqcfg;
        `GTU_A_STAT:   next_st.rdata = {3'h0, st.stat};
        `GTU_A_MASK:   next_st.rdata = {3'h0, st.mask};
        default:       next_st.rdata = `GTU_READ_NONE;
      endcase
    end
  end

  always_ff @(posedge clk_sys) begin
    if (sys_rst) begin
      st <= '0;
    end else begin
      st <= next_st;
    end
  end

  // ***************************************************************
  // Outputs
  // ***************************************************************
  // RL7 low flag gating
  assign irq_gate = {3'h7, st.cctl[`GTU_B_LOWEN], 1'b1};
  // RL6 high overflow interrupt
  assign irq      = |(st.stat & st.mask & irq_gate);
  assign rdata    = st.rdata;

  // ***************************************************************
  // Checks
  // ***************************************************************
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (sys_rst);

  sequence lo_wrap_s;
    split && lo_tick && st.clow == `GTU_BYTE_MAX && !wr;
  endsequence

  sequence lo_reloaded_s;
    st.clow == $past(st.crll) && st.stat[`GTU_S_LO];
  endsequence

  // RL15 low reload check
  split_lo_reload_a: assert property (lo_wrap_s |=> lo_reloaded_s) // RL15
    else $error("Low half did not reload on overflow");

  // RL3 low half runs
  lo_free_run_a: assert property (   // RL3
    (split && !run && lo_tick && st.clow != `GTU_BYTE_MAX && !wr)
      |=> st.clow == 8'($past(st.clow) + 8'h1))
    else $error("Low half stalled while run bit clear");

  // RL3 high half held
  hi_held_a: assert property ((split && !run && !wr) |=> $stable(st.chigh)) // RL3
    else $error("High half moved while run bit clear");

  // RL5 high flag set
  hi_flag_set_a: assert property (   // RL5
    (split && run && hi_tick && st.chigh == `GTU_BYTE_MAX) |=> st.stat[`GTU_S_HI])
    else $error("High overflow flag not set");

  // RL8 flag stays set
  flag_sticky_a: assert property (   // RL8
    (st.stat[`GTU_S_HI] && !(wr && addr == `GTU_A_STAT && wdata[`GTU_S_HI]))
      |=> st.stat[`GTU_S_HI])
    else $error("High overflow flag cleared by hardware");

  // RL7 low flag masked
  irq_low_gate_a: assert property (  // RL7
    ((st.stat & st.mask) == 5'h2 && !st.cctl[`GTU_B_LOWEN]) |-> !irq)
    else $error("Low overflow interrupted without enable");

  // RL4 divide by twelve
  div12_period_a: assert property (div12 |=> (!div12)[*8]) // RL4
    else $error("Divide by twelve tick too frequent");

  // RL14 capture loads reload
  capture_low_a: assert property (   // RL14
    (st.dctl[`GTU_B_CAPT] && pin_fall[P_CAP] && !wr) |=> st.drll == $past(st.dlow))
    else $error("Capture did not load reload low");

  // RL6 high overflow irq
  hi_irq_a: assert property (        // RL6
    (st.stat[`GTU_S_HI] && st.mask[`GTU_S_HI]) |-> irq)
    else $error("High overflow did not interrupt");

  // RL13 read data timing
  read_low_a: assert property ((rd && addr == `GTU_A_CLOW) |=> rdata == $past(st.clow)) // RL13
    else $error("Low byte read returned wrong value");
endmodule : gtu_top
`default_nettype wire

//--- hw/gtu_consts.svh
// Register offsets, bit positions, reset values and counts of the timer unit
`ifndef GTU_CONSTS_SVH
`define GTU_CONSTS_SVH

// ***************************************************************
// Register offsets
// ***************************************************************
`define GTU_A_LCTL   8'h88
`define GTU_A_MODE   8'h89
`define GTU_A_LA_LO  8'h8a
`define GTU_A_LB_LO  8'h8b
`define GTU_A_LA_HI  8'h8c
`define GTU_A_LB_HI  8'h8d
`define GTU_A_CKSEL  8'h8e
`define GTU_A_DCTL   8'h91
`define GTU_A_DRLL   8'h92
`define GTU_A_DLOW   8'h94
`define GTU_A_CCTL   8'hc8
`define GTU_A_CRLL   8'hca
`define GTU_A_CRLH   8'hcb
`define GTU_A_CLOW   8'hcc
`define GTU_A_CHIGH  8'hcd
`define GTU_A_IRQCFG 8'he4
`define GTU_A_STAT   8'he8
`define GTU_A_MASK   8'he9

// ***************************************************************
// Field positions
// ***************************************************************
`define GTU_B_XCLK   0
`define GTU_B_RUN    2
`define GTU_B_SPLIT  3
`define GTU_B_LOWEN  5
`define GTU_B_HSEL   5
`define GTU_B_LSEL   4
`define GTU_B_RUN_A  4
`define GTU_B_RUN_B  6
`define GTU_B_POL_A  3
`define GTU_B_POL_B  7
`define GTU_B_CAPT   0
`define GTU_B_GATE   3
`define GTU_B_CT     2
`define GTU_B_TMRB   4
`define GTU_S_HI     0
`define GTU_S_LO     1
`define GTU_S_LA     2
`define GTU_S_LB     3
`define GTU_S_CAP    4

// ***************************************************************
// Reset values and counts
// ***************************************************************
`define GTU_RST_REG  8'h00
`define GTU_READ_NONE 8'h00
`define GTU_BYTE_MAX 8'hff
`define GTU_PRE12_LAST 4'hb
`define GTU_EXT8_LAST 3'h7

`endif

//--- hw/gtu_pkg.sv
// Types shared by the timer unit
package gtu_pkg;

  typedef enum logic [1:0] {
    GTU_M13  = 2'h0,
    GTU_M16  = 2'h1,
    GTU_M8AR = 2'h2,
    GTU_M3   = 2'h3
  } gtu_lmode_t;

  typedef struct packed {
    logic [7:0] mode;
    logic [7:0] drll;
    logic [7:0] dlow;
    logic [7:0] dctl;
    logic [7:0] clow;
    logic [7:0] chigh;
    logic [7:0] crll;
    logic [7:0] crlh;
    logic [7:0] cctl;
    logic [7:0] cksel;
    logic [7:0] lctl;
    logic [7:0] irqcfg;
    logic [4:0] stat;
    logic [4:0] mask;
    logic [7:0] rdata;
    logic [3:0] pre12;
    logic [2:0] ext8;
  } gtu_state_t;

endpackage : gtu_pkg

//--- hw/gtu_sync.sv
// Two-flop synchroniser with edge detection for one pin
`timescale 1ns/100ps
`default_nettype none
module gtu_sync (
  // Clock and reset
  input  wire logic clk_sys,
  input  wire logic sys_rst,
  // Pin and results
  input  wire logic pin,
  output logic      level,
  output logic      rise,
  output logic      fall
);
  typedef struct packed {
    logic       s1;
    logic       s2;
    logic       s3;
    logic [2:0] vld;
  } gtu_sync_st_t;

  gtu_sync_st_t st;
  gtu_sync_st_t next_st;

  always_comb begin
    next_st    = st;
    next_st.s1 = pin;
    next_st.s2 = st.s1;
    next_st.s3 = st.s2;
    next_st.vld = {st.vld[1:0], 1'b1};
  end

  always_ff @(posedge clk_sys) begin
    if (sys_rst) begin
      st <= '0;
    end else begin
      st <= next_st;
    end
  end

  // Only the second and third flops are looked at; edges wait until the
  // third flop holds a real pin value, so no false edge follows reset
  assign level = st.s2;
  assign rise  = st.vld[2] & st.s2 & ~st.s3;
  assign fall  = st.vld[2] & st.s3 & ~st.s2;
endmodule : gtu_sync
`default_nettype wire

//--- hw/gtu_legacy.sv
// One legacy timer: gate, counter/timer select and four modes
`timescale 1ns/100ps
`default_nettype none
`include "gtu_consts.svh"
module gtu_legacy #(
  parameter bit SPLIT3 = 1'b0
) (
  // Clock and reset
  input  wire logic              clk_sys,
  input  wire logic              sys_rst,
  // Configuration
  input  wire logic              gate,
  input  wire logic              ct,
  input  wire gtu_pkg::gtu_lmode_t mode,
  input  wire logic              run,
  input  wire logic              run_hi,
  input  wire logic              irq_ok,
  // Count sources
  input  wire logic              tick,
  input  wire logic              pin_fall,
  // Software loads
  input  wire logic              ld_lo,
  input  wire logic              ld_hi,
  input  wire logic [7:0]        wdata,
  // Results
  output logic [7:0]             count_lo,
  output logic [7:0]             count_hi,
  output logic                   ovf,
  output logic                   ovf_hi
);
  typedef struct packed {
    logic [7:0] lo;
    logic [7:0] hi;
    logic       ovf;
    logic       ovf_hi;
  } gtu_leg_st_t;

  gtu_leg_st_t st;
  gtu_leg_st_t next_st;
  logic        en;
  logic        inc;

  // RL9 gate and run
  assign en  = run & (~gate | irq_ok);
  // RL10 timer or counter
  assign inc = en & (ct ? pin_fall : tick);

  always_comb begin
    next_st        = st;
    next_st.ovf    = 1'b0;
    next_st.ovf_hi = 1'b0;
    // RL12 mode field select
    case (mode)
      gtu_pkg::GTU_M13: begin
        if (inc) begin
          {next_st.hi, next_st.lo[4:0]} = 13'({st.hi, st.lo[4:0]} + 13'h1);
          next_st.ovf = &{st.hi, st.lo[4:0]};
        end
      end
      gtu_pkg::GTU_M16: begin
        if (inc) begin
          {next_st.hi, next_st.lo} = 16'({st.hi, st.lo} + 16'h1);
          next_st.ovf = &{st.hi, st.lo};
        end
      end
      gtu_pkg::GTU_M8AR: begin
        if (inc) begin
          next_st.lo  = (st.lo == `GTU_BYTE_MAX) ? st.hi : 8'(st.lo + 8'h1);
          next_st.ovf = (st.lo == `GTU_BYTE_MAX);
        end
      end
      gtu_pkg::GTU_M3: begin
        // RL11 second timer idle
        if (SPLIT3) begin
          if (inc) begin
            next_st.lo  = 8'(st.lo + 8'h1);
            next_st.ovf = (st.lo == `GTU_BYTE_MAX);
          end
          if (run_hi & tick) begin
            next_st.hi     = 8'(st.hi + 8'h1);
            next_st.ovf_hi = (st.hi == `GTU_BYTE_MAX);
          end
        end
      end
      default: begin
        next_st = st;
      end
    endcase
    if (ld_lo) begin
      next_st.lo = wdata;
    end
    if (ld_hi) begin
      next_st.hi = wdata;
    end
  end

  always_ff @(posedge clk_sys) begin
    if (sys_rst) begin
      st <= '0;
    end else begin
      st <= next_st;
    end
  end

  assign count_lo = st.lo;
  assign count_hi = st.hi;
  assign ovf      = st.ovf;
  assign ovf_hi   = st.ovf_hi;

  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (sys_rst);

  // RL9 gate holds count
  gate_hold_a: assert property (       // RL9
    (gate && !irq_ok && mode != gtu_pkg::GTU_M3 && !ld_lo && !ld_hi)
      |=> (st.lo == $past(st.lo)) && (st.hi == $past(st.hi)))
    else $error("Gated legacy timer counted");
endmodule : gtu_legacy
`default_nettype wire

//--- dv/gtu_tb.sv
// Self-checking testbench of the general-purpose timer unit
`timescale 1ns/100ps
`default_nettype none
`include "gtu_consts.svh"
module testbench;
  logic       clk_sys;
  logic       sys_rst;
  logic [7:0] addr;
  logic [7:0] wdata;
  logic       wr;
  logic       rd;
  logic [7:0] rdata;
  logic       ext_clk;
  logic [2:0] pins;
  logic       irq_a;
  logic       irq_b;
  logic       irq;
  logic [7:0] d;
  int         miscompares;
  int         comparisons;

  // ***************************************************************
  // Design and clock
  // ***************************************************************
  gtu_top dut_u (
    .clk_sys              (clk_sys),
    .sys_rst              (sys_rst),
    .addr                 (addr),
    .wdata                (wdata),
    .wr                   (wr),
    .rd                   (rd),
    .rdata                (rdata),
    .ext_clk_in           (ext_clk),
    .count_pin_a          (pins[0]),
    .count_pin_b          (pins[1]),
    .external_irq_input_a (irq_a),
    .external_irq_input_b (irq_b),
    .capture_pin          (pins[2]),
    .irq                  (irq)
  );

  initial begin
    clk_sys = 1'b0;
    forever #2.5 clk_sys = ~clk_sys;
  end

  // ***************************************************************
  // Tasks
  // ***************************************************************
  task automatic test_done();
    $display("comparisons %0d miscompares %0d", comparisons, miscompares);
    if (miscompares == 0 && comparisons > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask : test_done

  task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
    comparisons++;
    if (seen !== exp) begin
      miscompares++;
      $display("CHECK FAILED at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask : chk

  task automatic wr_reg(input logic [7:0] a, input logic [7:0] v);
    @(posedge clk_sys);
    wr    <= 1'b1;
    addr  <= a;
    wdata <= v;
    @(posedge clk_sys);
    wr <= 1'b0;
  endtask : wr_reg

  task automatic rd_reg(input logic [7:0] a);
    @(posedge clk_sys);
    rd   <= 1'b1;
    addr <= a;
    @(posedge clk_sys);
    rd <= 1'b0;
    #1;
    d = rdata;
  endtask : rd_reg

  task automatic rd_chk(input logic [7:0] a, input logic [7:0] exp);
    rd_reg(a);
    chk(d, exp);
  endtask : rd_chk

  task automatic stat_bit(input int b, input logic exp);
    rd_reg(`GTU_A_STAT);
    chk({7'h0, d[b]}, {7'h0, exp});
  endtask : stat_bit

  // Polls a status bit under a bounded count
  task automatic wait_stat(input int b);
    for (int i = 0; i < 300; i++) begin
      rd_reg(`GTU_A_STAT);
      if (d[b] === 1'b1) return;
    end
    miscompares++;
    test_done();
  endtask : wait_stat

  // Falling edges on the selected pins, slow enough for the synchroniser
  task automatic fall(input logic [2:0] m, input int n);
    repeat (n) begin
      @(posedge clk_sys);
      pins <= pins & ~m;
      repeat (4) @(posedge clk_sys);
      pins <= pins | m;
      repeat (4) @(posedge clk_sys);
    end
  endtask : fall

  task automatic ext_edges(input int n);
    repeat (n) begin
      repeat (3) @(posedge clk_sys);
      ext_clk <= 1'b1;
      repeat (3) @(posedge clk_sys);
      ext_clk <= 1'b0;
    end
  endtask : ext_edges

  // ***************************************************************
  // Main sequence
  // ***************************************************************
  initial begin
    miscompares = 0;
    comparisons = 0;
    sys_rst     = 1'b1;
    addr        = 8'h00;
    wdata       = 8'h00;
    wr          = 1'b0;
    rd          = 1'b0;
    ext_clk     = 1'b0;
    pins        = 3'b111;
    irq_a       = 1'b0;
    irq_b       = 1'b0;
    repeat (20) @(posedge clk_sys);
    sys_rst <= 1'b0;
    rd_chk(`GTU_A_MODE, 8'h00);
    rd_chk(`GTU_A_DRLL, 8'h00);
    rd_chk(`GTU_A_CLOW, 8'h00);
    chk({7'h0, irq}, 8'h00);
    wr_reg(8'h01, 8'hff);
    rd_chk(8'h01, 8'h00);
    rd_chk(`GTU_A_MODE, 8'h00);
    // External clock divided by 8 drives the low half
    wr_reg(`GTU_A_CKSEL, 8'h00);
    wr_reg(`GTU_A_CCTL, 8'h09);
    wr_reg(`GTU_A_CLOW, 8'h10);
    ext_edges(16);
    repeat (6) @(posedge clk_sys);
    rd_chk(`GTU_A_CLOW, 8'h12);
    // High half on system clock, gated by run for a known span
    wr_reg(`GTU_A_CKSEL, 8'h20);
    wr_reg(`GTU_A_CHIGH, 8'h10);
    wr_reg(`GTU_A_CCTL, 8'h0c);
    repeat (20) @(posedge clk_sys);
    wr_reg(`GTU_A_CCTL, 8'h08);
    rd_chk(`GTU_A_CHIGH, 8'h26);
    // Split halves on clock/12 with reloads and flags
    wr_reg(`GTU_A_CKSEL, 8'h00);
    wr_reg(`GTU_A_CRLL, 8'hfd);
    wr_reg(`GTU_A_CRLH, 8'hf0);
    wr_reg(`GTU_A_CLOW, 8'hfe);
    wr_reg(`GTU_A_CHIGH, 8'hfe);
    wr_reg(`GTU_A_MASK, 8'h03);
    wr_reg(`GTU_A_STAT, 8'h1f);
    wait_stat(1);
    rd_chk(`GTU_A_CLOW, 8'hfd);
    stat_bit(0, 1'b0);
    chk({7'h0, irq}, 8'h00);
    rd_chk(`GTU_A_CHIGH, 8'hfe);
    repeat (60) @(posedge clk_sys);
    stat_bit(1, 1'b1);
    wr_reg(`GTU_A_CCTL, 8'h28);
    #1;
    chk({7'h0, irq}, 8'h01);
    wr_reg(`GTU_A_STAT, 8'h02);
    stat_bit(1, 1'b0);
    wr_reg(`GTU_A_CCTL, 8'h0c);
    wr_reg(`GTU_A_MASK, 8'h01);
    wait_stat(0);
    chk({7'h0, irq}, 8'h01);
    rd_chk(`GTU_A_CHIGH, 8'hf0);
    wr_reg(`GTU_A_MASK, 8'h00);
    #1;
    chk({7'h0, irq}, 8'h00);
    wr_reg(`GTU_A_CCTL, 8'h00);
    wr_reg(`GTU_A_CLOW, 8'ha7);
    rd_chk(`GTU_A_CLOW, 8'ha7);
    // Non-split 16-bit count on system clock, two ticks into a reload
    wr_reg(`GTU_A_CKSEL, 8'h10);
    wr_reg(`GTU_A_CRLL, 8'h34);
    wr_reg(`GTU_A_CRLH, 8'h12);
    wr_reg(`GTU_A_CLOW, 8'hfe);
    wr_reg(`GTU_A_CHIGH, 8'hff);
    wr_reg(`GTU_A_STAT, 8'h1f);
    wr_reg(`GTU_A_CCTL, 8'h04);
    wr_reg(`GTU_A_CCTL, 8'h00);
    rd_chk(`GTU_A_CLOW, 8'h34);
    rd_chk(`GTU_A_CHIGH, 8'h12);
    stat_bit(0, 1'b1);
    // Legacy timers in counter mode, gate and modes
    wr_reg(`GTU_A_MODE, 8'h55);
    wr_reg(`GTU_A_LCTL, 8'h50);
    wr_reg(`GTU_A_LA_LO, 8'h00);
    wr_reg(`GTU_A_LB_LO, 8'h00);
    fall(3'b011, 3);
    rd_chk(`GTU_A_LA_LO, 8'h03);
    rd_chk(`GTU_A_LB_LO, 8'h03);
    wr_reg(`GTU_A_MODE, 8'h5d);
    wr_reg(`GTU_A_IRQCFG, 8'h08);
    fall(3'b001, 2);
    rd_chk(`GTU_A_LA_LO, 8'h03);
    @(posedge clk_sys);
    irq_a <= 1'b1;
    fall(3'b001, 2);
    rd_chk(`GTU_A_LA_LO, 8'h05);
    wr_reg(`GTU_A_MODE, 8'h75);
    rd_chk(`GTU_A_MODE, 8'h75);
    fall(3'b010, 2);
    rd_chk(`GTU_A_LB_LO, 8'h03);
    wr_reg(`GTU_A_MODE, 8'h06);
    wr_reg(`GTU_A_LA_HI, 8'h80);
    wr_reg(`GTU_A_LA_LO, 8'hff);
    wr_reg(`GTU_A_STAT, 8'h1f);
    fall(3'b001, 1);
    rd_chk(`GTU_A_LA_LO, 8'h80);
    stat_bit(2, 1'b1);
    // Timer A as an 8-bit counter and an 8-bit timer, timer B idle
    wr_reg(`GTU_A_MODE, 8'h37);
    wr_reg(`GTU_A_LA_HI, 8'hfe);
    wr_reg(`GTU_A_STAT, 8'h1f);
    wait_stat(3);
    rd_chk(`GTU_A_LA_HI, 8'h00);
    wr_reg(`GTU_A_LA_LO, 8'h10);
    fall(3'b001, 2);
    rd_chk(`GTU_A_LA_LO, 8'h12);
    // Capture of timer D low count into its reload low byte
    wr_reg(`GTU_A_DCTL, 8'h01);
    wr_reg(`GTU_A_DLOW, 8'h5a);
    fall(3'b100, 1);
    rd_chk(`GTU_A_DRLL, 8'h5a);
    stat_bit(4, 1'b1);
    // Timer D reloads its low byte on overflow
    wr_reg(`GTU_A_DRLL, 8'h77);
    wr_reg(`GTU_A_DLOW, 8'hff);
    wr_reg(`GTU_A_DCTL, 8'h04);
    d = 8'hff;
    for (int i = 0; i < 20 && d == 8'hff; i++) begin
      rd_reg(`GTU_A_DLOW);
    end
    chk(d, 8'h77);
    test_done();
  end

  // Cuts a hung run short
  initial begin
    repeat (100000) @(posedge clk_sys);
    miscompares++;
    test_done();
  end
endmodule : testbench
`default_nettype wire
